// *** hw/slt_defines.vh ***
// Register offsets, field positions, reset values and timing counts.
// Assumes an 8-bit register space reached through a local register port.
`ifndef SLT_DEFINES_VH
`define SLT_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SLT_ADDR_DIGITAL_RESET_CONTROL 8'h01
`define SLT_ADDR_DES_STATUS 8'h04
`define SLT_ADDR_PORT_SEL 8'h4C
`define SLT_ADDR_PORT_STS1 8'h4D
`define SLT_ADDR_BACK_CHANNEL_CONTROL 8'h49
`define SLT_ADDR_SER_GEN_STS 8'h52
`define SLT_ADDR_SER_ERR_CNT 8'h54
`define SLT_ADDR_DES_ERR_CNT 8'h57
`define SLT_ADDR_BACK_CHANNEL_CONFIGURATION 8'h58
`define SLT_ADDR_CC_ERR_STS 8'h79
`define SLT_ADDR_TEST_CTL 8'hB3
`define SLT_ADDR_PORT_DEBUG 8'hD0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SLT_BCC_PASS_ALL 7
`define SLT_BCC_PASS_DEC 6
`define SLT_BCC_AUTO_ACK 5
`define SLT_BCC_KEEP_ON 4
`define SLT_BCC_CRC_GEN 3
`define SLT_TCTL_ENABLE 0
`define SLT_TCTL_OSC 1
`define SLT_RST_SOFT 0
`define SLT_RST_HARD 1
`define SLT_RST_ROM 2
`define SLT_BCCTL_CLR_TEST 5
`define SLT_BCCTL_CLR_CRC 3
`define SLT_DBG_ONE 0
`define SLT_DBG_CONT 1
`define SLT_STS1_LOCK_CHG 4
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SLT_BACK_CHANNEL_CONFIGURATION_RST 8'h18
`define SLT_PORT_SEL_RST 8'h01
// ----------------------------------------
// Timing: ROM reload busy time, 1000 ns
// ----------------------------------------
`define SLT_ROM_LOAD_NS 1000
`define SLT_CLK_NS 4
`define SLT_ROM_LOAD_CYC ((`SLT_ROM_LOAD_NS + `SLT_CLK_NS - 1) / `SLT_CLK_NS)
`endif

// *** hw/slt_sync2.v ***
// Two-flop synchroniser for a bus of independent levels.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/10ps
module slt_sync2 #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] stage;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule // slt_sync2

// *** hw/slt_err_counter.v ***
// Saturating 8-bit error counter with clear; a new count in the clear cycle leaves 1.
// Assumes inc and clr are single-cycle strobes on clk_sys.
`timescale 1ns/10ps
module slt_err_counter #(
  parameter W = 8
) (
  input wire clk_sys,
  input wire rst_n,
  input wire inc,
  input wire clr,
  output reg [W-1:0] count
);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= {W{1'b0}};
    end else if (inc) begin
      // Event in the clear cycle still counts
      if (clr)
        count <= {{(W-1){1'b0}}, 1'b1};
      else if (count != {W{1'b1}})
        count <= count + {{(W-1){1'b0}}, 1'b1};
    end else if (clr) begin
      count <= {W{1'b0}};
    end
  end
endmodule // slt_err_counter

// *** hw/slt_link_test.v ***
// Link self-test and back-channel control registers of a deserializer,
// with the serializer-side status, clear and counter registers alongside.
// Assumes a synchronous register port on clk_sys; link events are pins.
//
// Operation
// - Bit 7 passes all local transactions through
// - Bit 6 forwards only on address match
// - Bit 5 acknowledges every write locally
// - Bit 4 keeps back channel always on
// - Bit 3 enables back-channel CRC generator
// - Bits 2:0 rate, strapped at power-down release
// - Control bit starts and stops self-test
// - Test clock: pixel clock or oscillator
// - Self-test enable sent over back channel
// - Pattern errors counted per receive port
// - Serializer counts back-channel CRC failures
// - Reset bits: soft, hard (writable registers only), ROM reload
// - Status: checksum, init, refclk, pass, lock
// - Lock only with PLL and recovery valid
// - Serializer general status bit layout
// - Port writes only for enabled ports
// - Self-clearing bits clear serializer counter and test error flag
// - Reading error status clears linked flag
// - Lock change flag, set on any lock transition
// - Debug bits inject one or continuous errors
// - Test holds channel; clearing restores normal
`timescale 1ns/10ps
`include "slt_defines.vh"
module slt_link_test #(
  parameter NPORT = 2,
  parameter ROM_CYC = `SLT_ROM_LOAD_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regLocalMaster,
  output reg [7:0] regRdata,
  input wire powerDownRelease,
  input wire [2:0] rateStrap,
  input wire pllLocked,
  input wire cdrValid,
  input wire refClkValid,
  input wire configChecksumOk,
  input wire pixelClockPresent,
  input wire [NPORT-1:0] patternError,
  input wire backChannelCrcError,
  input wire backChannelLinkLost,
  input wire serRxLock,
  input wire serHsLock,
  input wire serLinkDetect,
  input wire [3:0] controlChannelError,
  input wire i2cAddrMatch,
  output reg passThroughAll,
  output reg passThroughDecoded,
  output reg autoAckAll,
  output reg backChannelRun,
  output reg crcGenEnable,
  output reg [2:0] backChannelRate,
  output reg selfTestEnable,
  output reg selfTestOscillator,
  output reg injectError,
  output reg softResetPulse,
  output reg romReloadBusy
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  localparam SW = 14 + NPORT;
  wire [SW-1:0] syncOut;
  slt_sync2 #(.W(SW)) uSync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din({powerDownRelease, pllLocked, cdrValid, refClkValid, configChecksumOk,
      pixelClockPresent, backChannelCrcError, backChannelLinkLost, serRxLock,
      serHsLock, serLinkDetect, controlChannelError[2:0], patternError}),
    .dout(syncOut)
  );
  wire pdrS = syncOut[SW-1];
  wire pllS = syncOut[SW-2];
  wire cdrS = syncOut[SW-3];
  wire refS = syncOut[SW-4];
  wire cksS = syncOut[SW-5];
  wire pclkS = syncOut[SW-6];
  wire crcErrS = syncOut[SW-7];
  wire linkLostS = syncOut[SW-8];
  wire rxLockS = syncOut[SW-9];
  wire hsLockS = syncOut[SW-10];
  wire detS = syncOut[SW-11];
  wire [2:0] ccErrS = syncOut[SW-12:SW-14];
  wire [NPORT-1:0] patErrS = syncOut[NPORT-1:0];
  // Bit 3 of control error is synchronised here, then latched in status and flagged
  reg ccErr3S0;
  reg ccErr3S;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] bccConfig;
  reg [7:0] portSel;
  reg [7:0] testCtl;
  reg [1:0] dbgCont;
  reg [3:0] ccErrStatus;
  reg ccErrFlag;
  reg [NPORT-1:0] lockChange;
  reg lockPrev;
  reg pdrPrev;
  reg [15:0] romCnt;
  reg [NPORT-1:0] prevPat;
  reg prevCrc;
  reg clrSerCnt;
  reg [NPORT-1:0] clrDesCnt;
  reg testErrSticky;
  wire [7:0] serCnt;
  wire [8*NPORT-1:0] desCnt;

  function isWr;
    input [7:0] a;
    begin
      isWr = regWrite && (regAddr == a);
    end
  endfunction

  wire linkLock = pllS & cdrS;
  wire hardRst = isWr(`SLT_ADDR_DIGITAL_RESET_CONTROL) && regWdata[`SLT_RST_HARD];
  wire [NPORT-1:0] patInc = patErrS & ~prevPat & {NPORT{selfTestEnable}};
  wire crcInc = crcErrS & ~prevCrc & selfTestEnable;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ccErr3S0 <= 1'b0;
      ccErr3S <= 1'b0;
    end else begin
      ccErr3S0 <= controlChannelError[3];
      ccErr3S <= ccErr3S0;
    end
  end

  // ----------------------------------------
  // Register writes and side effects
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bccConfig <= `SLT_BACK_CHANNEL_CONFIGURATION_RST;
      portSel <= `SLT_PORT_SEL_RST;
      testCtl <= 8'h00;
      dbgCont <= 2'b00;
      ccErrStatus <= 4'h0;
      ccErrFlag <= 1'b0;
      lockChange <= {NPORT{1'b0}};
      lockPrev <= 1'b0;
      pdrPrev <= 1'b0;
      romCnt <= 16'h0000;
      prevPat <= {NPORT{1'b0}};
      prevCrc <= 1'b0;
      clrSerCnt <= 1'b0;
      clrDesCnt <= {NPORT{1'b0}};
      testErrSticky <= 1'b0;
      injectError <= 1'b0;
      softResetPulse <= 1'b0;
    end else begin
      pdrPrev <= pdrS;
      lockPrev <= linkLock;
      prevPat <= patErrS;
      prevCrc <= crcErrS;
      clrSerCnt <= 1'b0;
      clrDesCnt <= {NPORT{1'b0}};
      softResetPulse <= 1'b0;
      dbgCont[0] <= 1'b0;
      if (pdrS && !pdrPrev)
        bccConfig[2:0] <= rateStrap;
      if (hardRst) begin
        bccConfig <= `SLT_BACK_CHANNEL_CONFIGURATION_RST;
        portSel <= `SLT_PORT_SEL_RST;
        testCtl <= 8'h00;
        dbgCont <= 2'b00;
      end else if (regWrite) begin
        if (regAddr == `SLT_ADDR_BACK_CHANNEL_CONFIGURATION) begin
          bccConfig[7:5] <= regWdata[7:5];
          // Keep-on bit only from the local master
          if (regLocalMaster)
            bccConfig[`SLT_BCC_KEEP_ON] <= regWdata[`SLT_BCC_KEEP_ON];
          bccConfig[`SLT_BCC_CRC_GEN] <= regWdata[`SLT_BCC_CRC_GEN];
          // Reserved codes 001..011 are refused
          if (regWdata[2] || regWdata[1:0] == 2'b00)
            bccConfig[2:0] <= regWdata[2:0];
        end else if (regAddr == `SLT_ADDR_PORT_SEL) begin
          portSel <= regWdata;
        end else if (regAddr == `SLT_ADDR_TEST_CTL) begin
          testCtl <= regWdata;
        end else if (regAddr == `SLT_ADDR_PORT_DEBUG) begin
          // Port debug is paged: honoured only for enabled ports
          if (|portSel[NPORT-1:0])
            dbgCont <= regWdata[1:0];
        end else if (regAddr == `SLT_ADDR_BACK_CHANNEL_CONTROL) begin
          clrSerCnt <= regWdata[`SLT_BCCTL_CLR_TEST];
          if (regWdata[`SLT_BCCTL_CLR_CRC])
            testErrSticky <= 1'b0;
        end else if (regAddr == `SLT_ADDR_DES_ERR_CNT) begin
          clrDesCnt <= portSel[NPORT-1:0];
        end
      end
      if (isWr(`SLT_ADDR_DIGITAL_RESET_CONTROL) && regWdata[`SLT_RST_SOFT])
        softResetPulse <= 1'b1;
      // Single injection self-clears; continuous holds until cleared
      injectError <= dbgCont[0] | dbgCont[1];
      if (crcInc)
        testErrSticky <= 1'b1;
      // Error status: set wins over read clear
      if (regRead && regAddr == `SLT_ADDR_CC_ERR_STS) begin
        ccErrStatus <= {ccErr3S, ccErrS};
        ccErrFlag <= |{ccErr3S, ccErrS};
      end else begin
        ccErrStatus <= ccErrStatus | {ccErr3S, ccErrS};
        ccErrFlag <= ccErrFlag | (|{ccErr3S, ccErrS});
      end
      // Lock change per port, cleared by reading its status when selected
      if (regRead && regAddr == `SLT_ADDR_PORT_STS1)
        lockChange <= (lockChange & ~portSel[NPORT-1:0]) |
          {NPORT{linkLock ^ lockPrev}};
      else
        lockChange <= lockChange | {NPORT{linkLock ^ lockPrev}};
      if (isWr(`SLT_ADDR_DIGITAL_RESET_CONTROL) && regWdata[`SLT_RST_ROM])
        romCnt <= ROM_CYC[15:0];
      else if (romCnt != 16'h0000)
        romCnt <= romCnt - 16'h0001;
    end
  end

  slt_err_counter #(.W(8)) uSerCnt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inc(crcInc),
    .clr(clrSerCnt),
    .count(serCnt)
  );

  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : gPort
      slt_err_counter #(.W(8)) uDesCnt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .inc(patInc[g]),
        .clr(clrDesCnt[g]),
        .count(desCnt[8*g+7:8*g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Outputs from flops
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      passThroughAll <= 1'b0;
      passThroughDecoded <= 1'b0;
      autoAckAll <= 1'b0;
      backChannelRun <= 1'b1;
      crcGenEnable <= 1'b1;
      backChannelRate <= 3'b000;
      selfTestEnable <= 1'b0;
      selfTestOscillator <= 1'b0;
      romReloadBusy <= 1'b0;
    end else begin
      // Test owns the whole channel, so passthrough is held off
      passThroughAll <= bccConfig[`SLT_BCC_PASS_ALL] & ~testCtl[0];
      passThroughDecoded <= bccConfig[`SLT_BCC_PASS_DEC] & i2cAddrMatch &
        ~testCtl[0];
      autoAckAll <= bccConfig[`SLT_BCC_AUTO_ACK];
      backChannelRun <= bccConfig[`SLT_BCC_KEEP_ON] | bccConfig[`SLT_BCC_PASS_ALL] |
        bccConfig[`SLT_BCC_PASS_DEC] | testCtl[0];
      crcGenEnable <= bccConfig[`SLT_BCC_CRC_GEN];
      backChannelRate <= bccConfig[2:0];
      selfTestEnable <= testCtl[`SLT_TCTL_ENABLE];
      // Oscillator forced when no pixel clock is seen
      selfTestOscillator <= testCtl[`SLT_TCTL_OSC] | ~pclkS;
      romReloadBusy <= (romCnt != 16'h0000);
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  reg [7:0] next_rdata;
  integer i;
  always @* begin
    next_rdata = 8'h00;
    if (regAddr == `SLT_ADDR_BACK_CHANNEL_CONFIGURATION) begin
      next_rdata = bccConfig;
    end else if (regAddr == `SLT_ADDR_DES_STATUS) begin
      next_rdata = {cksS, ~romReloadBusy, 1'b0, refS, linkLock, linkLock, 2'b11};
    end else if (regAddr == `SLT_ADDR_SER_GEN_STS) begin
      next_rdata = {1'b0, rxLockS, 1'b0, linkLostS, testErrSticky, hsLockS,
        ccErrFlag, detS};
    end else if (regAddr == `SLT_ADDR_SER_ERR_CNT) begin
      next_rdata = serCnt;
    end else if (regAddr == `SLT_ADDR_DES_ERR_CNT) begin
      for (i = NPORT - 1; i >= 0; i = i - 1)
        if (portSel[i])
          next_rdata = desCnt[8*i +: 8];
    end else if (regAddr == `SLT_ADDR_PORT_SEL) begin
      next_rdata = portSel;
    end else if (regAddr == `SLT_ADDR_TEST_CTL) begin
      next_rdata = testCtl;
    end else if (regAddr == `SLT_ADDR_PORT_DEBUG) begin
      next_rdata = {6'b000000, dbgCont};
    end else if (regAddr == `SLT_ADDR_CC_ERR_STS) begin
      next_rdata = {4'h0, ccErrStatus};
    end else if (regAddr == `SLT_ADDR_PORT_STS1) begin
      for (i = NPORT - 1; i >= 0; i = i - 1)
        if (portSel[i])
          next_rdata = {3'b000, lockChange[i], 2'b00, linkLock, linkLock};
    end else if (regAddr == `SLT_ADDR_DIGITAL_RESET_CONTROL) begin
      next_rdata = 8'h00;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      regRdata <= 8'h00;
    else if (regRead)
      regRdata <= next_rdata;
  end
endmodule // slt_link_test

// *** test/slt_link_test_checker.sv ***
// Port-level checker for the link self-test block.
// Assumes register writes reach the outputs two edges after the request.
`timescale 1ns/10ps
module slt_link_test_checker #(
  parameter NPORT = 2,
  parameter ROM_CYC = 4
) (
  input wire clk_sys,
  input wire rst_n,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regLocalMaster,
  input wire [7:0] regRdata,
  input wire passThroughAll,
  input wire autoAckAll,
  input wire backChannelRun,
  input wire crcGenEnable,
  input wire [2:0] backChannelRate,
  input wire selfTestEnable,
  input wire softResetPulse,
  input wire romReloadBusy
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  reg [7:0] wd1;
  reg [7:0] wd2;
  wire w58 = regWrite && regAddr == 8'h58;
  always @(posedge clk_sys) begin
    wd1 <= regWdata;
    wd2 <= wd1;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  pass_all_a: assert property (w58 |-> ##2 passThroughAll == (wd2[7] & !selfTestEnable))
    else $error("pass all output wrong");
  auto_ack_a: assert property (w58 |-> ##2 autoAckAll == wd2[5])
    else $error("auto ack output wrong");
  crc_gen_a: assert property (w58 |-> ##2 crcGenEnable == wd2[3])
    else $error("crc enable output wrong");
  rate_set_a: assert property (w58 && (regWdata[2:0] == 3'h0 || regWdata[2])
    |-> ##2 backChannelRate == wd2[2:0]) else $error("rate not taken");
  rate_keep_a: assert property (w58 && regWdata[2:0] != 3'h0 && !regWdata[2]
    |=> $stable(backChannelRate) [*2]) else $error("reserved rate taken");
  bc_off_a: assert property (w58 && regLocalMaster && regWdata[7:4] == 4'h0
    |-> ##2 !backChannelRun) else $error("back channel still on");
  bc_on_a: assert property (w58 && regLocalMaster && regWdata[4] |-> ##2 backChannelRun)
    else $error("back channel not kept on");
  test_en_a: assert property (regWrite && regAddr == 8'hB3 |-> ##2 selfTestEnable == wd2[0])
    else $error("self test enable wrong");
  test_hold_a: assert property (selfTestEnable && $past(selfTestEnable) |-> !passThroughAll)
    else $error("pass through during test");
  soft_cause_a: assert property (regWrite && regAddr == 8'h01 && regWdata[0]
    |-> ##[1:2] softResetPulse) else $error("no soft reset pulse");
  soft_pulse_a: assert property (softResetPulse |=> !softResetPulse)
    else $error("soft reset pulse too long");
  rom_busy_a: assert property ($rose(romReloadBusy) |-> romReloadBusy [*3])
    else $error("reload busy too short");
  read_zero_a: assert property (regRead && (regAddr == 8'h01 || regAddr == 8'h02)
    |=> regRdata == 8'h00) else $error("read not zero");
  status_fix_a: assert property (regRead && regAddr == 8'h04
    |=> regRdata[5] == 1'b0 && regRdata[1:0] == 2'b11) else $error("status fixed bits wrong");
endmodule // slt_link_test_checker

bind slt_link_test slt_link_test_checker #(.NPORT(NPORT), .ROM_CYC(ROM_CYC)) u_slt_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
  .regAddr(regAddr), .regWdata(regWdata), .regLocalMaster(regLocalMaster),
  .regRdata(regRdata), .passThroughAll(passThroughAll), .autoAckAll(autoAckAll),
  .backChannelRun(backChannelRun), .crcGenEnable(crcGenEnable),
  .backChannelRate(backChannelRate), .selfTestEnable(selfTestEnable),
  .softResetPulse(softResetPulse), .romReloadBusy(romReloadBusy));

// *** test/slt_ser_model.sv ***
// Far-end serializer model: healthy link levels, test errors on injection with the oscillator test clock.
// Assumes injectError and the test controls come straight from the block.
`timescale 1ns/10ps
module slt_ser_model (
  input wire clk_sys,
  input wire selfTestEnable,
  input wire selfTestOscillator,
  input wire injectError,
  output wire backChannelCrcError,
  output wire [1:0] patternError,
  output wire serRxLock,
  output wire serHsLock,
  output wire serLinkDetect,
  output wire backChannelLinkLost,
  output wire [3:0] controlChannelError
);
  reg [2:0] hit = 3'h0;
  // Stretched so the two-flop input sync cannot miss it
  always @(posedge clk_sys) begin
    hit <= {hit[1:0], injectError & selfTestEnable & selfTestOscillator};
  end
  assign backChannelCrcError = |hit;
  assign patternError = {1'b0, |hit};
  assign serRxLock = 1'b1;
  assign serHsLock = 1'b1;
  assign serLinkDetect = 1'b1;
  assign backChannelLinkLost = 1'b0;
  assign controlChannelError = 4'h0;
endmodule // slt_ser_model

// *** test/serdes_link_bist_and_back_channel_configuration_tb_top.sv ***
// Self-checking bench for the link self-test block.
// Assumes the far-end model drives the serializer-side inputs.
`timescale 1ns/10ps
module serdes_link_bist_and_back_channel_configuration_tb_top;
  reg clk_sys = 0;
  reg rst_n = 0;
  reg regWrite = 0;
  reg regRead = 0;
  reg regLocalMaster = 1;
  reg powerDownRelease = 0;
  reg cdrValid = 1;
  reg pllLocked = 1;
  // Healthy status word has the reference clock flag low
  reg refClkValid = 0;
  reg [2:0] rateStrap = 3'h0;
  reg pixelClockPresent = 1;
  reg i2cAddrMatch = 0;
  reg [7:0] regAddr = 8'h00;
  reg [7:0] regWdata = 8'h00;
  reg [7:0] bcc;
  reg [7:0] w;
  reg lm;
  integer seed;
  integer i;
  integer cycles = 0;
  integer mismatches = 0;
  integer total_checks = 0;
  wire [7:0] regRdata;
  wire [1:0] patternError;
  wire [3:0] controlChannelError;
  wire backChannelCrcError, backChannelLinkLost, serRxLock, serHsLock, serLinkDetect;
  wire passThroughAll, passThroughDecoded, autoAckAll, backChannelRun, crcGenEnable;
  wire selfTestEnable, selfTestOscillator, injectError, softResetPulse, romReloadBusy;
  wire [2:0] backChannelRate;
  slt_link_test #(.NPORT(2), .ROM_CYC(4)) u_slt_link_test (.clk_sys(clk_sys), .rst_n(rst_n),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regLocalMaster(regLocalMaster), .regRdata(regRdata), .powerDownRelease(powerDownRelease),
    .rateStrap(rateStrap), .pllLocked(pllLocked), .cdrValid(cdrValid),
    .refClkValid(refClkValid),
    .configChecksumOk(1'b1), .pixelClockPresent(pixelClockPresent),
    .patternError(patternError), .backChannelCrcError(backChannelCrcError),
    .backChannelLinkLost(backChannelLinkLost), .serRxLock(serRxLock), .serHsLock(serHsLock),
    .serLinkDetect(serLinkDetect), .controlChannelError(controlChannelError),
    .i2cAddrMatch(i2cAddrMatch), .passThroughAll(passThroughAll),
    .passThroughDecoded(passThroughDecoded), .autoAckAll(autoAckAll),
    .backChannelRun(backChannelRun), .crcGenEnable(crcGenEnable),
    .backChannelRate(backChannelRate), .selfTestEnable(selfTestEnable),
    .selfTestOscillator(selfTestOscillator), .injectError(injectError),
    .softResetPulse(softResetPulse), .romReloadBusy(romReloadBusy));
  slt_ser_model u_slt_ser_model (.clk_sys(clk_sys), .selfTestEnable(selfTestEnable),
    .selfTestOscillator(selfTestOscillator), .injectError(injectError),
    .backChannelCrcError(backChannelCrcError), .patternError(patternError),
    .serRxLock(serRxLock), .serHsLock(serHsLock), .serLinkDetect(serLinkDetect),
    .backChannelLinkLost(backChannelLinkLost), .controlChannelError(controlChannelError));
  // ----------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Gap after each write keeps the checker's two-edge windows apart
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  task rd(input [7:0] a, input [7:0] e, input [7:0] m);
    begin
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      @(posedge clk_sys);
      chk(regRdata & m, e & m);
    end
  endtask
  function [7:0] bcc_next(input [7:0] o, input [7:0] d, input l);
    begin
      bcc_next = d;
      if (!l) bcc_next[4] = o[4];
      if (d[2:0] != 3'h0 && !d[2]) bcc_next[2:0] = o[2:0];
    end
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h03b3_f426;
    rateStrap <= $random(seed);
    repeat (5) @(posedge clk_sys);
    chk({4'h0, backChannelRun, crcGenEnable, passThroughAll, selfTestEnable}, 8'h0C);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    powerDownRelease <= 1'b1;
    repeat (6) @(posedge clk_sys);
    bcc = {5'h03, rateStrap};
    rd(8'h58, bcc, 8'hFF);
    wr(8'h58, bcc | 8'h20);
    bcc = bcc | 8'h20;
    for (i = 0; i < 16; i = i + 1) begin
      w = (i == 0) ? 8'h23 : (i == 1) ? 8'h00 : (i == 2) ? 8'hFF : $random(seed);
      lm = (i < 3) ? 1'b1 : $random(seed);
      regLocalMaster <= lm;
      i2cAddrMatch <= $random(seed);
      wr(8'h58, w);
      bcc = bcc_next(bcc, w, lm);
      rd(8'h58, bcc, 8'hFF);
      chk({passThroughAll, autoAckAll, crcGenEnable, backChannelRate}, {bcc[7], bcc[5], bcc[3:0]});
      chk({7'h0, passThroughDecoded}, {7'h0, bcc[6] & i2cAddrMatch});
      chk({7'h0, backChannelRun}, {7'h0, bcc[4] | bcc[7] | bcc[6]});
    end
    regLocalMaster <= 1'b1;
    wr(8'h58, 8'hFE);
    bcc = 8'hFE;
    $display("config test done");
    rd(8'h04, 8'hCF, 8'hFF);
    rd(8'h52, 8'h45, 8'hFF);
    rd(8'h02, 8'h00, 8'hFF);
    cdrValid <= 1'b0;
    refClkValid <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(8'h04, 8'hD3, 8'hFF);
    cdrValid <= 1'b1;
    pllLocked <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rd(8'h04, 8'hD3, 8'hFF);
    pllLocked <= 1'b1;
    refClkValid <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rd(8'h4D, 8'h10, 8'h10);
    $display("status test done");
    pixelClockPresent <= 1'b0;
    wr(8'h49, 8'h28);
    rd(8'h79, 8'h00, 8'h0F);
    rd(8'h54, 8'h00, 8'hFF);
    wr(8'h57, 8'h00);
    wr(8'hB3, 8'h01);
    chk({6'h0, selfTestOscillator, passThroughAll}, 8'h02);
    wr(8'hD0, 8'h01);
    repeat (8) @(posedge clk_sys);
    rd(8'h54, 8'h01, 8'hFF);
    rd(8'h52, 8'h4D, 8'hFF);
    rd(8'h57, 8'h01, 8'hFF);
    wr(8'h4C, 8'h02);
    rd(8'h57, 8'h00, 8'hFF);
    wr(8'h4C, 8'h00);
    wr(8'hD0, 8'h02);
    chk({7'h0, injectError}, 8'h00);
    wr(8'h4C, 8'h01);
    wr(8'hD0, 8'h02);
    repeat (4) @(posedge clk_sys);
    chk({7'h0, injectError}, 8'h01);
    wr(8'hD0, 8'h00);
    chk({7'h0, injectError}, 8'h00);
    wr(8'hB3, 8'h00);
    chk({6'h0, selfTestEnable, passThroughAll}, 8'h01);
    rd(8'h54, 8'h02, 8'hFF);
    rd(8'h57, 8'h02, 8'hFF);
    wr(8'h49, 8'h28);
    rd(8'h54, 8'h00, 8'hFF);
    rd(8'h52, 8'h45, 8'hFF);
    wr(8'h57, 8'h00);
    rd(8'h57, 8'h00, 8'hFF);
    $display("self test done");
    wr(8'h01, 8'h01);
    rd(8'h58, bcc, 8'hFF);
    wr(8'h01, 8'h04);
    chk({7'h0, romReloadBusy}, 8'h01);
    repeat (20) @(posedge clk_sys);
    chk({7'h0, romReloadBusy}, 8'h00);
    rd(8'h04, 8'hCF, 8'hFF);
    wr(8'h01, 8'h02);
    repeat (6) @(posedge clk_sys);
    rd(8'h58, 8'h18, 8'hF8);
    $display("reset test done");
    give_verdict;
  end
endmodule // serdes_link_bist_and_back_channel_configuration_tb_top
